// file: design/feiu_params.svh
// Offsets, field positions, reset values and edge masks of the event unit.
`ifndef FEIU_PARAMS_SVH
`define FEIU_PARAMS_SVH

// --------------------------------------------------------------------
// Register byte offsets
// --------------------------------------------------------------------
`define FEIU_OFS_ENABLE_CFG 4'h0
`define FEIU_OFS_EVENT_STAT 4'h4
`define FEIU_OFS_IRQ_STAT 4'h8
`define FEIU_OFS_IRQ_MASK 4'hC

// --------------------------------------------------------------------
// Field positions in the enable and status registers
// --------------------------------------------------------------------
`define FEIU_BIT_OUT_DIS 15
`define FEIU_BIT_READY 4
`define FEIU_BIT_POR 2
`define FEIU_BIT_ECC2 1
`define FEIU_BIT_ECC1 0

// --------------------------------------------------------------------
// Reset values
// --------------------------------------------------------------------
`define FEIU_CFG_RESET 16'hFFFF
`define FEIU_STAT_HW_RESET 16'hFFFF
`define FEIU_STAT_POR_RESET 16'hFFFB
`define FEIU_IRQ_RESET 3'h0
`define FEIU_RDATA_IDLE 16'h0000

// --------------------------------------------------------------------
// Event detection: a 1 marks a rising-edge channel, a 0 a falling one
// --------------------------------------------------------------------
`define FEIU_RISE_MASK 3'h3

`endif

// file: design/feiu_pkg.sv
// Types shared by the event unit modules.
package feiu_pkg;

  typedef logic [15:0] feiu_data_t;
  typedef logic [3:0] feiu_addr_t;

  // One bit per internal event; bit 2 ready, bit 1 ecc2, bit 0 ecc1.
  typedef struct packed {
    logic ready;
    logic ecc2;
    logic ecc1;
  } feiu_evt_t;

endpackage : feiu_pkg

// file: design/feiu_event_detect.sv
// Edge detector that turns internal event levels into one-cycle pulses.
`timescale 1ns/10ps
`include "feiu_params.svh"

module feiu_event_detect (
  input wire logic clk,
  input wire logic rst_n,
  input feiu_pkg::feiu_evt_t level,
  output feiu_pkg::feiu_evt_t pulse
);
  import feiu_pkg::*;

  localparam logic [2:0] RISE = `FEIU_RISE_MASK;

  logic [2:0] cur;
  logic [2:0] prev;
  logic [2:0] hit;

  assign cur = level;
  assign pulse = hit;

  // The previous value resets to the active level of each channel, so a
  // level already active at reset release is not taken as an event.
  for (genvar i = 0; i < 3; i++) begin : g_edge
    always_ff @(posedge clk) begin
      if (!rst_n) begin
        prev[i] <= RISE[i];
      end else begin
        prev[i] <= cur[i];
      end
    end
    assign hit[i] = RISE[i] ? (cur[i] & ~prev[i]) : (prev[i] & ~cur[i]);
  end

endmodule : feiu_event_detect

// file: design/feiu_top.sv
// Interrupt event unit: enable and status registers, open-drain pin, IRQ.
//
// Notes on behaviour
// [RULE_01] The interrupt pin is open drain: only ever pulled low, else released.
// [RULE_02] Enable register bit 15 at 0 lets enabled events pull the pin.
// [RULE_03] Enable bit 4 at 0 lets busy-to-ready transitions pull the pin.
// [RULE_04] Enable bit 1 at 0 lets 2-bit ECC errors pull the pin.
// [RULE_05] Enable bit 0 at 0 lets 1-bit ECC errors pull the pin.
// [RULE_06] With the pin enabled, an enabled event pulls the pin low.
// [RULE_07] Writing 1 to enable bit 15 sets every status flag back to 1; the code leaves status bit 2 (power-on) as it is.
// [RULE_08] Writing 1 to an event enable bit sets its status flag to 1.
// [RULE_09] Pin stays low while any enabled status flag reads 0.
// [RULE_10] Status bit 4 reads 0 after a busy-to-ready transition.
// [RULE_11] Status bits 1 and 0 read 0 after 2-bit or 1-bit ECC errors.
// [RULE_12] Status writes only turn bits to 1; only events turn them to 0.
// [RULE_13] Both resets load the enable register with all ones; pin floats.
// [RULE_14] Hardware reset sets every status bit to 1.
// [RULE_15] Power-on reset clears status bit 2 and sets the others.
// [RULE_16] Status bit 2 returns to 1 only by hardware reset or a write.
// [RULE_17] Status bit 2 never affects the interrupt pin.
// [RULE_18] The host reads the status register after seeing the pin low.
// [RULE_19] Each event is a one-cycle pulse and clears its flag once.
//
// The plain strobed port and the placing of the registers were decided locally.
`timescale 1ns/10ps
`include "feiu_params.svh"

module feiu_top (
  input wire logic REF_CLK,
  input wire logic RSTN,
  input wire logic HW_RESET_N,
  input wire logic BUSY,
  input wire logic ECC2_ERR,
  input wire logic ECC1_ERR,
  input wire feiu_pkg::feiu_addr_t ADDR,
  input wire feiu_pkg::feiu_data_t WDATA,
  input wire logic WR,
  input wire logic RD,
  output feiu_pkg::feiu_data_t RDATA,
  output logic INT_O,
  output logic INT_OE,
  output logic IRQ
);
  import feiu_pkg::*;

  // --------------------------------------------------------------------
  // Channel map: channel 2 ready, channel 1 ecc2, channel 0 ecc1
  // --------------------------------------------------------------------
  localparam int CH_BIT [3] = '{`FEIU_BIT_ECC1, `FEIU_BIT_ECC2,
                                `FEIU_BIT_READY};

  feiu_data_t interrupt_enable_config;
  feiu_data_t interrupt_event_status;
  feiu_data_t next_rdata;
  feiu_evt_t ev_level;
  feiu_evt_t ev_pulse;
  logic [2:0] pulse_v;
  logic [2:0] flag_n;
  logic [2:0] ch_en_n;
  logic [2:0] irq_stat;
  logic [2:0] irq_mask;
  logic por_flag;
  logic hw_rst;
  logic wr_cfg;
  logic wr_stat;
  logic wr_irq_stat;
  logic wr_irq_mask;
  logic pin_cond;

  // --------------------------------------------------------------------
  // Event detection
  // --------------------------------------------------------------------
  assign ev_level.ready = BUSY;
  assign ev_level.ecc2 = ECC2_ERR;
  assign ev_level.ecc1 = ECC1_ERR;

  // The ready event is the falling edge of busy; the errors are rising
  // edges, so a held error strobe counts only once.
  feiu_event_detect u_detect (
    .clk(REF_CLK),
    .rst_n(RSTN),
    .level(ev_level),
    .pulse(ev_pulse)
  ); // [RULE_19]

  assign pulse_v = ev_pulse;

  // --------------------------------------------------------------------
  // Register decode
  // --------------------------------------------------------------------
  assign hw_rst = !HW_RESET_N;
  assign wr_cfg = WR && (ADDR == `FEIU_OFS_ENABLE_CFG);
  assign wr_stat = WR && (ADDR == `FEIU_OFS_EVENT_STAT);
  assign wr_irq_stat = WR && (ADDR == `FEIU_OFS_IRQ_STAT);
  assign wr_irq_mask = WR && (ADDR == `FEIU_OFS_IRQ_MASK);

  // --------------------------------------------------------------------
  // Enable register
  // --------------------------------------------------------------------
  // Reserved bits are kept as written, since they are plain read/write.
  always_ff @(posedge REF_CLK) begin
    if (!RSTN || hw_rst) begin
      interrupt_enable_config <= `FEIU_CFG_RESET; // [RULE_13]
    end else if (wr_cfg) begin
      interrupt_enable_config <= WDATA;
    end
  end

  // --------------------------------------------------------------------
  // Event status flags, active low
  // --------------------------------------------------------------------
  // Only enabled events are recorded, so a flag reset by disabling its
  // channel stays quiet until the channel is enabled again. An event in
  // the same cycle as a write that sets the flag wins.
  for (genvar i = 0; i < 3; i++) begin : g_ch
    assign ch_en_n[i] = interrupt_enable_config[CH_BIT[i]];
    always_ff @(posedge REF_CLK) begin
      if (!RSTN || hw_rst) begin
        flag_n[i] <= 1'b1; // [RULE_14]
      end else if (pulse_v[i] && !ch_en_n[i]) begin
        flag_n[i] <= 1'b0; // [RULE_10] [RULE_11] [RULE_19]
      end else if (wr_cfg && WDATA[`FEIU_BIT_OUT_DIS]) begin
        flag_n[i] <= 1'b1; // [RULE_07]
      end else if (wr_cfg && WDATA[CH_BIT[i]]) begin
        flag_n[i] <= 1'b1; // [RULE_08]
      end else if (wr_stat && WDATA[CH_BIT[i]]) begin
        flag_n[i] <= 1'b1; // [RULE_12]
      end
    end
  end

  // --------------------------------------------------------------------
  // Power-on-detect flag
  // --------------------------------------------------------------------
  always_ff @(posedge REF_CLK) begin
    if (!RSTN) begin
      por_flag <= 1'b0; // [RULE_15]
    end else if (hw_rst) begin
      por_flag <= 1'b1; // [RULE_16]
    end else if (wr_stat && WDATA[`FEIU_BIT_POR]) begin
      por_flag <= 1'b1; // [RULE_16]
    end
  end

  // Reserved status bits have no event and so always read as 1.
  always_comb begin
    interrupt_event_status = `FEIU_STAT_HW_RESET;
    interrupt_event_status[`FEIU_BIT_READY] = flag_n[2]; // [RULE_10]
    interrupt_event_status[`FEIU_BIT_ECC2] = flag_n[1]; // [RULE_11]
    interrupt_event_status[`FEIU_BIT_ECC1] = flag_n[0]; // [RULE_11]
    interrupt_event_status[`FEIU_BIT_POR] = por_flag;
  end

  // --------------------------------------------------------------------
  // Open-drain interrupt pin
  // --------------------------------------------------------------------
  // The power-on-detect flag is left out of the term on purpose.
  assign pin_cond = !interrupt_enable_config[`FEIU_BIT_OUT_DIS] &&
                    |(~flag_n & ~ch_en_n); // [RULE_02] [RULE_09] [RULE_17]

  always_ff @(posedge REF_CLK) begin
    if (!RSTN || hw_rst) begin
      INT_OE <= 1'b0; // [RULE_13]
    end else begin
      INT_OE <= pin_cond; // [RULE_03] [RULE_04] [RULE_05] [RULE_06]
    end
  end

  // The pin is never driven high; a pull-up outside restores it.
  always_ff @(posedge REF_CLK) begin
    INT_O <= 1'b0; // [RULE_01]
  end

  // --------------------------------------------------------------------
  // System interrupt: sticky event bits, mask, level output
  // --------------------------------------------------------------------
  // These see every event, enabled or not, so firmware inside the chip
  // can follow the flash without touching the host-facing pin.
  always_ff @(posedge REF_CLK) begin
    if (!RSTN) begin
      irq_stat <= `FEIU_IRQ_RESET;
    end else if (wr_irq_stat) begin
      irq_stat <= (irq_stat & ~WDATA[2:0]) | pulse_v;
    end else begin
      irq_stat <= irq_stat | pulse_v;
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (!RSTN) begin
      irq_mask <= `FEIU_IRQ_RESET;
    end else if (wr_irq_mask) begin
      irq_mask <= WDATA[2:0];
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (!RSTN) begin
      IRQ <= 1'b0;
    end else begin
      IRQ <= |(irq_stat & irq_mask);
    end
  end

  // --------------------------------------------------------------------
  // Read data, valid only in the cycle after the read strobe
  // --------------------------------------------------------------------
  always_comb begin
    next_rdata = `FEIU_RDATA_IDLE;
    if (RD) begin
      case (ADDR)
        `FEIU_OFS_ENABLE_CFG: begin
          next_rdata = interrupt_enable_config;
        end
        `FEIU_OFS_EVENT_STAT: begin
          next_rdata = interrupt_event_status; // [RULE_18]
        end
        `FEIU_OFS_IRQ_STAT: begin
          next_rdata = {13'h0000, irq_stat};
        end
        `FEIU_OFS_IRQ_MASK: begin
          next_rdata = {13'h0000, irq_mask};
        end
        default: begin
          next_rdata = `FEIU_RDATA_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (!RSTN) begin
      RDATA <= `FEIU_RDATA_IDLE;
    end else begin
      RDATA <= next_rdata;
    end
  end

  // --------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RSTN);

  a_pin_only_low: assert property (INT_O == 1'b0) // [RULE_01]
    else $error("interrupt pin driven high");

  a_out_dis_gate: assert property ( // [RULE_02]
    interrupt_enable_config[`FEIU_BIT_OUT_DIS] |=> !INT_OE)
    else $error("pin pulled while output disabled");

  a_ready_pulls_pin: assert property ( // [RULE_03]
    ev_pulse.ready && !interrupt_enable_config[`FEIU_BIT_OUT_DIS] &&
    !interrupt_enable_config[`FEIU_BIT_READY] && !WR && HW_RESET_N
    ##1 !WR && HW_RESET_N |=> INT_OE)
    else $error("ready event did not pull the pin");

  a_ecc2_pulls_pin: assert property ( // [RULE_04]
    ev_pulse.ecc2 && !interrupt_enable_config[`FEIU_BIT_OUT_DIS] &&
    !interrupt_enable_config[`FEIU_BIT_ECC2] && !WR && HW_RESET_N
    ##1 !WR && HW_RESET_N |=> INT_OE)
    else $error("2-bit error did not pull the pin");

  a_ecc1_pulls_pin: assert property ( // [RULE_05]
    ev_pulse.ecc1 && !interrupt_enable_config[`FEIU_BIT_OUT_DIS] &&
    !interrupt_enable_config[`FEIU_BIT_ECC1] && !WR && HW_RESET_N
    ##1 !WR && HW_RESET_N |=> INT_OE)
    else $error("1-bit error did not pull the pin");

  a_disabled_quiet: assert property ( // [RULE_03]
    ev_pulse.ready && interrupt_enable_config[`FEIU_BIT_READY] &&
    interrupt_event_status[`FEIU_BIT_READY] |=>
    interrupt_event_status[`FEIU_BIT_READY])
    else $error("disabled ready event recorded");

  a_out_dis_clears: assert property ( // [RULE_07]
    wr_cfg && WDATA[`FEIU_BIT_OUT_DIS] && !(|pulse_v) |=>
    &flag_n ##1 !INT_OE)
    else $error("status not cleared by output disable");

  a_chan_dis_clears: assert property ( // [RULE_08]
    wr_cfg && WDATA[`FEIU_BIT_ECC2] && !ev_pulse.ecc2 |=>
    interrupt_event_status[`FEIU_BIT_ECC2])
    else $error("channel disable did not clear its flag");

  // A hardware reset one cycle later legally releases the pin, so the
  // second cycle is only checked when the reset pin stays high.
  a_pin_holds_low: assert property ( // [RULE_09]
    pin_cond && !WR && HW_RESET_N ##1 HW_RESET_N |->
    INT_OE ##1 INT_OE)
    else $error("pin released with a pending enabled flag");

  a_pin_released: assert property ( // [RULE_09]
    !pin_cond |=> !INT_OE)
    else $error("pin held low with no pending enabled flag");

  a_event_clears: assert property ( // [RULE_11]
    ev_pulse.ecc1 && !interrupt_enable_config[`FEIU_BIT_ECC1] &&
    HW_RESET_N |=> !interrupt_event_status[`FEIU_BIT_ECC1])
    else $error("1-bit error flag not recorded");

  a_write_no_clear: assert property ( // [RULE_12]
    wr_stat && !WDATA[`FEIU_BIT_READY] && HW_RESET_N &&
    !ev_pulse.ready && interrupt_event_status[`FEIU_BIT_READY] |=>
    interrupt_event_status[`FEIU_BIT_READY])
    else $error("status write turned a bit to 0");

  a_write_sets: assert property ( // [RULE_12]
    wr_stat && WDATA[`FEIU_BIT_READY] && !ev_pulse.ready |=>
    interrupt_event_status[`FEIU_BIT_READY])
    else $error("status write did not set the bit");

  a_hw_reset_load: assert property ( // [RULE_13] [RULE_14]
    hw_rst |=> interrupt_enable_config == `FEIU_CFG_RESET &&
    interrupt_event_status == `FEIU_STAT_HW_RESET &&
    !INT_OE)
    else $error("hardware reset values wrong");

  a_por_values: assert property ( // [RULE_13] [RULE_15]
    $rose(RSTN) |-> interrupt_event_status == `FEIU_STAT_POR_RESET &&
    interrupt_enable_config == `FEIU_CFG_RESET &&
    !INT_OE)
    else $error("power-on reset values wrong");

  a_por_flag_sticky: assert property ( // [RULE_16]
    !por_flag && HW_RESET_N && !wr_stat |=> !por_flag)
    else $error("power-on flag set without cause");

  a_por_no_pin: assert property ( // [RULE_17]
    !por_flag && (&flag_n) |=> !INT_OE)
    else $error("power-on flag affected the pin");

  a_event_one_cycle: assert property ( // [RULE_19]
    ev_pulse.ready |=> !ev_pulse.ready)
    else $error("ready event longer than one cycle");

  a_busy_fall_event: assert property ( // [RULE_19]
    $fell(BUSY) |-> ev_pulse.ready)
    else $error("busy fall not detected");

  a_irq_level: assert property (
    |(irq_stat & irq_mask) |=> IRQ)
    else $error("system interrupt not raised");

  a_irq_w1c: assert property (
    wr_irq_stat && WDATA[0] && !pulse_v[0] |=> !irq_stat[0])
    else $error("system interrupt bit not cleared by write");

  a_rdata_idle: assert property (
    !RD |=> RDATA == `FEIU_RDATA_IDLE)
    else $error("read data not idle after a cycle without read");

  c_pin_low: cover property (!INT_OE ##1 INT_OE);
  c_pin_release: cover property (INT_OE ##1 !INT_OE);
  c_event_and_clear: cover property (
    ev_pulse.ready && wr_stat && WDATA[`FEIU_BIT_READY]);
  c_por_write: cover property (!por_flag ##1 por_flag);

endmodule : feiu_top

// file: bench/feiu_host_model.sv
// Host-side interrupt input of the event unit, with its pull-up resistor.
`timescale 1ns/10ps

module feiu_host_model (
  input wire logic clk,
  input wire logic int_o,
  input wire logic int_oe,
  output logic pin_n,
  output logic seen_low
);
  // The pull-up wins whenever the device lets go of the pin.
  assign pin_n = int_oe ? int_o : 1'b1;

  // A low pin tells the host that the status register needs a read.
  always @(posedge clk) begin
    seen_low <= (seen_low === 1'b1) || (pin_n === 1'b0);
  end
endmodule : feiu_host_model

// file: bench/flash_event_interrupt_unit_tb.sv
// Self-checking testbench of the flash event interrupt unit.
`timescale 1ns/10ps
`include "feiu_params.svh"

module flash_event_interrupt_unit_tb;
  import feiu_pkg::*;
  typedef struct {
    int ev;
    feiu_data_t cfg;
    feiu_data_t stat;
    logic pin;
  } feiu_row_t;
  logic ref_clk = 1'b0;
  logic rstn = 1'b0;
  logic hw_reset_n = 1'b1;
  logic busy = 1'b0;
  logic ecc2_err = 1'b0;
  logic ecc1_err = 1'b0;
  feiu_addr_t addr = 4'h0;
  feiu_data_t wdata = 16'h0000;
  logic wr_s = 1'b0;
  logic rd_s = 1'b0;
  feiu_data_t rdata;
  logic int_o;
  logic int_oe;
  logic irq;
  logic pin_n;
  logic seen_low;
  int bad_count = 0;
  int n_compared = 0;
  // Channel 0 ready, 1 two-bit error, 2 one-bit error.
  feiu_row_t rows [7] = '{
    '{0, 16'h7FEC, 16'hFFEF, 1'b0},
    '{1, 16'h7FEC, 16'hFFFD, 1'b0},
    '{2, 16'h7FEC, 16'hFFFE, 1'b0},
    '{0, 16'h7FFC, 16'hFFFF, 1'b1},
    '{1, 16'h7FEE, 16'hFFFF, 1'b1},
    '{2, 16'h7FED, 16'hFFFF, 1'b1},
    '{0, 16'hFFEC, 16'hFFEF, 1'b1}
  };

  always #12.5 ref_clk = ~ref_clk;

  feiu_top uut (
    .REF_CLK(ref_clk),
    .RSTN(rstn),
    .HW_RESET_N(hw_reset_n),
    .BUSY(busy),
    .ECC2_ERR(ecc2_err),
    .ECC1_ERR(ecc1_err),
    .ADDR(addr),
    .WDATA(wdata),
    .WR(wr_s),
    .RD(rd_s),
    .RDATA(rdata),
    .INT_O(int_o),
    .INT_OE(int_oe),
    .IRQ(irq)
  );

  feiu_host_model host (
    .clk(ref_clk),
    .int_o(int_o),
    .int_oe(int_oe),
    .pin_n(pin_n),
    .seen_low(seen_low)
  );

  // ------------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------------
  task automatic chk(string nm, feiu_data_t exp, feiu_data_t got);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic rpt(int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : rpt

  task automatic wr(feiu_addr_t a, feiu_data_t d);
    @(posedge ref_clk);
    wr_s <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge ref_clk);
    wr_s <= 1'b0;
  endtask : wr

  // Read data stand only in the cycle after the strobe, so look there.
  task automatic rd(feiu_addr_t a, feiu_data_t exp);
    @(posedge ref_clk);
    rd_s <= 1'b1;
    addr <= a;
    @(posedge ref_clk);
    rd_s <= 1'b0;
    #1;
    chk("rdata", exp, rdata);
  endtask : rd

  task automatic ev(int k);
    @(posedge ref_clk);
    case (k)
      0: busy <= 1'b1;
      1: ecc2_err <= 1'b1;
      default: ecc1_err <= 1'b1;
    endcase
    @(posedge ref_clk);
    busy <= 1'b0;
    ecc2_err <= 1'b0;
    ecc1_err <= 1'b0;
  endtask : ev

  task automatic pin(logic exp);
    chk("pin", {15'h0000, exp}, {15'h0000, pin_n});
  endtask : pin

  task automatic end_of_test();
    if (bad_count == 0 && n_compared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : end_of_test

  // The whole run takes a few hundred cycles; this limit is generous.
  initial begin
    #100000;
    bad_count++;
    end_of_test();
  end

  // ------------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------------
  initial begin
    repeat (5) @(posedge ref_clk);
    rstn <= 1'b1;
    rd(`FEIU_OFS_EVENT_STAT, `FEIU_STAT_POR_RESET);
    rd(`FEIU_OFS_ENABLE_CFG, `FEIU_CFG_RESET);
    wr(`FEIU_OFS_ENABLE_CFG, 16'h7FEC);
    rpt(3);
    pin(1'b1);
    wr(`FEIU_OFS_EVENT_STAT, 16'h0004);
    rd(`FEIU_OFS_EVENT_STAT, 16'hFFFF);
    wr(`FEIU_OFS_IRQ_MASK, 16'h0007);
    foreach (rows[i]) begin
      wr(`FEIU_OFS_ENABLE_CFG, rows[i].cfg);
      ev(rows[i].ev);
      rpt(4);
      pin(rows[i].pin);
      chk("irq", 16'h0001, {15'h0000, irq});
      rd(`FEIU_OFS_EVENT_STAT, rows[i].stat);
      wr(`FEIU_OFS_EVENT_STAT, 16'hFFFF);
      wr(`FEIU_OFS_IRQ_STAT, 16'h0007);
      rpt(2);
      pin(1'b1);
      chk("irq", 16'h0000, {15'h0000, irq});
    end
    // Two flags pending: clearing one must not release the pin.
    wr(`FEIU_OFS_ENABLE_CFG, 16'h7FEC);
    ev(1);
    ev(2);
    rpt(4);
    wr(`FEIU_OFS_EVENT_STAT, 16'h0002);
    rpt(2);
    pin(1'b0);
    wr(`FEIU_OFS_EVENT_STAT, 16'h0000);
    rd(`FEIU_OFS_EVENT_STAT, 16'hFFFE);
    wr(`FEIU_OFS_EVENT_STAT, 16'h0001);
    rpt(2);
    pin(1'b1);
    // Disabling one channel restores its flag.
    ev(2);
    rpt(4);
    pin(1'b0);
    wr(`FEIU_OFS_ENABLE_CFG, 16'h7FED);
    rpt(2);
    pin(1'b1);
    rd(`FEIU_OFS_EVENT_STAT, 16'hFFFF);
    // Disabling the pin restores every event flag.
    wr(`FEIU_OFS_ENABLE_CFG, 16'h7FEC);
    ev(0);
    ev(1);
    rpt(4);
    pin(1'b0);
    wr(`FEIU_OFS_ENABLE_CFG, 16'hFFEC);
    rpt(2);
    pin(1'b1);
    rd(`FEIU_OFS_EVENT_STAT, 16'hFFFF);
    // Hardware reset with a flag pending.
    wr(`FEIU_OFS_ENABLE_CFG, 16'h7FEC);
    ev(2);
    rpt(4);
    pin(1'b0);
    @(posedge ref_clk);
    hw_reset_n <= 1'b0;
    @(posedge ref_clk);
    hw_reset_n <= 1'b1;
    rpt(2);
    pin(1'b1);
    rd(`FEIU_OFS_ENABLE_CFG, `FEIU_CFG_RESET);
    rd(`FEIU_OFS_EVENT_STAT, `FEIU_STAT_HW_RESET);
    // An unmapped place ignores writes and reads as zero.
    wr(4'h2, 16'h1234);
    rd(4'h2, 16'h0000);
    rd(`FEIU_OFS_ENABLE_CFG, `FEIU_CFG_RESET);
    rpt(1);
    chk("rdata_idle", `FEIU_RDATA_IDLE, rdata);
    chk("seen_low", 16'h0001, {15'h0000, seen_low});
    // Power-on reset again in mid-run.
    @(posedge ref_clk);
    rstn <= 1'b0;
    repeat (2) @(posedge ref_clk);
    rstn <= 1'b1;
    rd(`FEIU_OFS_EVENT_STAT, `FEIU_STAT_POR_RESET);
    rd(`FEIU_OFS_ENABLE_CFG, `FEIU_CFG_RESET);
    end_of_test();
  end
endmodule : flash_event_interrupt_unit_tb
